//--- verilog/lsfp_regs.svh
`ifndef LSFP_REGS_SVH
`define LSFP_REGS_SVH
// ----------------------------------------------------------------
// status codes, reset values and timing
// ----------------------------------------------------------------
`define LSFP_CH             6
`define LSFP_CODE_NOT_DONE  3'h7
`define LSFP_CODE_SCB       3'h6
`define LSFP_CODE_GLO       3'h5
`define LSFP_CODE_OLF       3'h3
`define LSFP_CODE_SCG       3'h2
`define LSFP_CODE_NO_OFF    3'h4
`define LSFP_CODE_NO_ON     3'h1
`define LSFP_CODE_DONE      3'h0
`define LSFP_MODE_RESET     6'h00
`define LSFP_OLEN_RESET     6'h3f
`define LSFP_CLK_MHZ        40
`define LSFP_FILTER_NS      10000
`define LSFP_FILTER_CYC     ((`LSFP_FILTER_NS * `LSFP_CLK_MHZ) / 1000)
`endif

//--- verilog/lsfp_pkg.sv
package lsfp_pkg;
	// per-channel protection sequencer state
	typedef enum logic [1:0] {
		LSFP_RUN   = 2'b00,
		LSFP_LATCH = 2'b01,
		LSFP_RETRY = 2'b10
	} lsfp_prot_t;
endpackage : lsfp_pkg

//--- verilog/lsfp_top.sv
`timescale 1ns/1ps
`include "lsfp_regs.svh"
//
// Contract
// - each channel has its own 3-bit shorted-load threshold select, eight steps
// - shorted load flagged when drain exceeds threshold at blanking or filter end
// - one host-writable recovery mode bit per channel, six channels
// - latch-off mode, the default, keeps gate off after shorted load
// - disable then re-enable releases every latched channel
// - status read then diagnostic pulse request releases chosen channels
// - auto-retry holds channel off for retry interval, then follows command
// - retry timer resets on disable or switch to latch-off without codes
// - after retry, re-enabled channel rechecked at blanking end, repeats
// - mode change applies at once when no shorted-load or latched code
// - retry to latch-off waits until a status read clears shorted-load code
// - latch-off to retry waits until read and unlatch clear both codes
// - off channel: above open-load ok, below short ground, between open
// - diagnostics off under reset or disable; open-load follows enable bits or an off pulse
// - open-load enable bit 0 off, 1 on, reset default 1
// - fault flag low on any channel fault with reset, select high, enabled
// - fault flag released during reset, select low or disable high
// - 3-bit priority status: shorted load over ground short over open load
// - comparisons run continuously but latch only at timer expiry
// - all blanking timers start on reset release or disable release
// - command change starts blanking timer; abnormal at expiry latches fault
// - comparison change starts filter timer; abnormal at expiry latches fault
// - latch-off read of shorted-load status becomes latched code until release
// - gate on only when enabled, not shut down, and commanded or pulsed on
module lsfp_top #(
	parameter int unsigned RETRY_CYC  = 400000,
	parameter int unsigned BLANK_UNIT = 400
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	// global control pins
	input  wire logic        reset_input_n,
	input  wire logic        global_disable,
	input  wire logic        chip_select_n,
	// commands
	input  wire logic [5:0]  parallel_input,
	input  wire logic [5:0]  gate_command_bit,
	input  wire logic [5:0]  recovery_mode_bits,
	input  wire logic [5:0]  open_load_enable_bits,
	input  wire logic [17:0] short_threshold_select,
	input  wire logic [11:0] blanking_select,
	input  wire logic [5:0]  status_read,
	input  wire logic [5:0]  pulse_on_req,
	input  wire logic [5:0]  pulse_off_req,
	// comparator results
	input  wire logic [5:0]  drain_above_short_threshold,
	input  wire logic [5:0]  drain_above_open_load_reference,
	input  wire logic [5:0]  drain_below_short_ground_reference,
	// outputs
	output logic [5:0]       gate_output,
	output logic [17:0]      threshold_to_comparator,
	output logic [5:0]       active_mode,
	output logic [17:0]      status_code,
	output logic [5:0]       short_shutdown_state,
	output logic             fault_flag_n_out,
	output logic             fault_flag_n_oe
);

	// ----------------------------------------------------------------
	// global qualifiers and edge detection
	// ----------------------------------------------------------------
	logic enabled;
	logic enabled_q;
	logic start_all;
	logic [5:0] cmd;
	logic [5:0] cmd_q;
	localparam int unsigned FILT = (`LSFP_FILTER_CYC < 1) ? 1 : `LSFP_FILTER_CYC;
	// recovery mode reset pattern, one bit per channel, latch-off everywhere
	localparam logic [5:0] MODE_RST = `LSFP_MODE_RESET;

	assign enabled = reset_input_n && !global_disable;
	assign cmd     = parallel_input | gate_command_bit;
	assign start_all = enabled && !enabled_q;

	// remember enable for release edges; por start comes from the reset itself
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			enabled_q <= 1'b0;
			cmd_q     <= 6'h00;
		end else begin
			enabled_q <= enabled;
			cmd_q     <= cmd;
		end
	end

	// ----------------------------------------------------------------
	// per-channel logic
	// ----------------------------------------------------------------
	logic [5:0] chan_fault;

	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : ch
			logic [31:0]  blank_cnt;
			logic [31:0]  filt_cnt;
			logic [31:0]  retry_cnt;
			logic         blank_end;
			logic         filt_end;
			logic         gate_on;
			logic         cmp;
			logic         cmp_q;
			logic         abnormal;
			logic [2:0]   new_code;
			logic [2:0]   st;
			logic         mode;
			lsfp_pkg::lsfp_prot_t prot;
			logic         pulse_req;
			logic         pulse_act;
			logic         pulse_off;
			logic [31:0]  blank_len;

			// ----------------------------------------------------------------
			// diagnostic pulse acceptance
			// ----------------------------------------------------------------
			// both pulse kinds at once, a stored shorted load or retry refuse the pulse
			// a running blanking timer also refuses it, so pulses cannot overlap
			// and a pulse can never cut short the settling of a command change
			assign pulse_req = (pulse_on_req[g] ^ pulse_off_req[g]) && enabled
				&& st != `LSFP_CODE_SCB && prot != lsfp_pkg::LSFP_RETRY && blank_cnt == 0;

			// ----------------------------------------------------------------
			// gate drive
			// ----------------------------------------------------------------
			// gate drive, pulse overrides the command
			// any protection state other than run keeps the gate low
			assign gate_on = enabled && prot == lsfp_pkg::LSFP_RUN
				&& (pulse_act ? !pulse_off : cmd[g]);

			// blanking step from select field, one unit per code plus one
			// a new select only takes effect at the next load of the timer
			assign blank_len = 32'(blanking_select[g*2 +: 2] + 1) * BLANK_UNIT;

			// ----------------------------------------------------------------
			// drain comparison and candidate code
			// ----------------------------------------------------------------
			// comparison tracks the current state continuously
			// the result is only a candidate; it is stored at timer expiry alone
			always_comb begin
				if (gate_on) begin
					cmp      = drain_above_short_threshold[g];
					abnormal = drain_above_short_threshold[g];
					new_code = abnormal ? `LSFP_CODE_SCB : `LSFP_CODE_NO_ON;
				end else if (drain_above_open_load_reference[g]) begin
					cmp      = 1'b1;
					abnormal = 1'b0;
					new_code = `LSFP_CODE_NO_OFF;
				end else if (drain_below_short_ground_reference[g]) begin
					cmp      = 1'b0;
					abnormal = 1'b1;
					new_code = `LSFP_CODE_SCG;
				end else begin
					cmp      = 1'b0;
					abnormal = open_load_enable_bits[g] || (pulse_act && pulse_off);
					new_code = abnormal ? `LSFP_CODE_OLF : `LSFP_CODE_NO_OFF;
				end
			end

			// ----------------------------------------------------------------
			// blanking and filter timers
			// ----------------------------------------------------------------
			// blanking timer: global start, command change, pulse, retry restart
			// expiry is the cycle in which the count reads one
			always_ff @(posedge mclk) begin
				if (!resetn) begin
					blank_cnt <= 32'(BLANK_UNIT);
				end else if (!enabled) begin
					blank_cnt <= 0;
				end else if (start_all || cmd[g] != cmd_q[g] || pulse_req
					|| (prot == lsfp_pkg::LSFP_RETRY && retry_cnt == 1)) begin
					blank_cnt <= blank_len;
				end else if (blank_cnt != 0) begin
					blank_cnt <= blank_cnt - 1;
				end
			end
			assign blank_end = enabled && blank_cnt == 1;

			// filter timer restarts on every comparison change
			// a glitch shorter than the filter interval therefore never latches
			always_ff @(posedge mclk) begin
				if (!resetn) begin
					cmp_q    <= 1'b0;
					filt_cnt <= 0;
				end else begin
					cmp_q <= cmp;
					if (!enabled)
						filt_cnt <= 0;
					else if (cmp != cmp_q)
						filt_cnt <= FILT;
					else if (filt_cnt != 0)
						filt_cnt <= filt_cnt - 1;
				end
			end
			assign filt_end = enabled && filt_cnt == 1;

			// ----------------------------------------------------------------
			// diagnostic pulse state
			// ----------------------------------------------------------------
			// pulse holds the opposite state for its blanking time
			always_ff @(posedge mclk) begin
				if (!resetn) begin
					pulse_act <= 1'b0;
					pulse_off <= 1'b0;
				end else if (pulse_req) begin
					pulse_act <= 1'b1;
					pulse_off <= pulse_off_req[g];
				end else if (blank_end || !enabled) begin
					pulse_act <= 1'b0;
				end
			end

			// ----------------------------------------------------------------
			// status memory
			// ----------------------------------------------------------------
			// status memory: latch at timer expiry only, never demote
			// a stored fault is only replaced by a fault of higher priority;
			// a latch event in the same cycle as a read wins over the read
			always_ff @(posedge mclk) begin
				if (!resetn) begin
					st <= `LSFP_CODE_NOT_DONE;
				end else if (enabled && (blank_end || filt_end)
					&& (abnormal || gate_on || open_load_enable_bits[g] || pulse_act)
					&& (new_code == `LSFP_CODE_SCB || !chan_fault[g]
					|| (st == `LSFP_CODE_OLF && new_code == `LSFP_CODE_SCG))) begin
					st <= new_code;
				end else if (status_read[g]) begin
					if (st == `LSFP_CODE_SCB && !mode)
						st <= `LSFP_CODE_GLO;
					else if (st != `LSFP_CODE_GLO)
						st <= `LSFP_CODE_NOT_DONE;
				end else if (st == `LSFP_CODE_GLO && prot != lsfp_pkg::LSFP_LATCH) begin
					st <= `LSFP_CODE_NOT_DONE;
				end
			end

			// ----------------------------------------------------------------
			// recovery mode
			// ----------------------------------------------------------------
			// active mode follows request only when no protecting code is stored
			// so a pending change waits for the read or unlatch that clears it
			always_ff @(posedge mclk) begin
				if (!resetn)
					mode <= MODE_RST[g];
				else if (st != `LSFP_CODE_SCB && st != `LSFP_CODE_GLO)
					mode <= recovery_mode_bits[g];
			end

			// ----------------------------------------------------------------
			// protection sequencer
			// ----------------------------------------------------------------
			// protection sequencer
			// disable wins over every state and clears the retry timer
			always_ff @(posedge mclk) begin
				if (!resetn) begin
					prot      <= lsfp_pkg::LSFP_RUN;
					retry_cnt <= 0;
				end else if (global_disable) begin
					retry_cnt <= 0;
					if (prot == lsfp_pkg::LSFP_LATCH || prot == lsfp_pkg::LSFP_RETRY)
						prot <= lsfp_pkg::LSFP_RUN;
				end else begin
					unique case (prot)
						lsfp_pkg::LSFP_RUN: begin
							if (gate_on && abnormal && (blank_end || filt_end)) begin
								if (mode) begin
									prot      <= lsfp_pkg::LSFP_RETRY;
									retry_cnt <= RETRY_CYC;
								end else begin
									prot <= lsfp_pkg::LSFP_LATCH;
								end
							end
						end
						lsfp_pkg::LSFP_LATCH: begin
							if (st == `LSFP_CODE_GLO && pulse_on_req[g] ^ pulse_off_req[g])
								prot <= lsfp_pkg::LSFP_RUN;
						end
						lsfp_pkg::LSFP_RETRY: begin
							if (!mode && st != `LSFP_CODE_SCB && st != `LSFP_CODE_GLO) begin
								prot      <= lsfp_pkg::LSFP_RUN;
								retry_cnt <= 0;
							end else if (retry_cnt <= 1) begin
								prot      <= lsfp_pkg::LSFP_RUN;
								retry_cnt <= 0;
							end else begin
								retry_cnt <= retry_cnt - 1;
							end
						end
						default: prot <= lsfp_pkg::LSFP_RUN;
					endcase
				end
			end

			// any stored fault code pulls the shared flag
			assign chan_fault[g] = st == `LSFP_CODE_SCB || st == `LSFP_CODE_GLO
				|| st == `LSFP_CODE_SCG || st == `LSFP_CODE_OLF;

			// ----------------------------------------------------------------
			// registered outputs
			// ----------------------------------------------------------------
			// registered outputs
			always_ff @(posedge mclk) begin
				if (!resetn) begin
					gate_output[g]               <= 1'b0;
					threshold_to_comparator[g*3 +: 3] <= 3'h0;
					active_mode[g]               <= 1'b0;
					status_code[g*3 +: 3]        <= `LSFP_CODE_NOT_DONE;
					short_shutdown_state[g]      <= 1'b0;
				end else begin
					gate_output[g]               <= gate_on;
					threshold_to_comparator[g*3 +: 3] <= short_threshold_select[g*3 +: 3];
					active_mode[g]               <= mode;
					status_code[g*3 +: 3]        <= st;
					short_shutdown_state[g]      <= prot != lsfp_pkg::LSFP_RUN;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// open-drain fault flag
	// ----------------------------------------------------------------
	// released under reset, select low or disable; pulled low on any fault
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			fault_flag_n_out <= 1'b0;
			fault_flag_n_oe  <= 1'b0;
		end else begin
			fault_flag_n_out <= 1'b0;
			fault_flag_n_oe  <= enabled && chip_select_n && |chan_fault;
		end
	end

endmodule : lsfp_top

//--- verification/lsfp_top_props.sv
`timescale 1ns/1ps
`include "lsfp_regs.svh"
// ---
// port checker
// ---
module lsfp_top_chk (
	// clock and reset
	input wire logic        mclk,
	input wire logic        resetn,
	// control pins
	input wire logic        reset_input_n,
	input wire logic        global_disable,
	input wire logic        chip_select_n,
	input wire logic [5:0]  recovery_mode_bits,
	input wire logic [17:0] short_threshold_select,
	// outputs
	input wire logic [5:0]  gate_output,
	input wire logic [17:0] threshold_to_comparator,
	input wire logic [5:0]  active_mode,
	input wire logic [17:0] status_code,
	input wire logic [5:0]  short_shutdown_state,
	input wire logic        fault_flag_n_out,
	input wire logic        fault_flag_n_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	logic [5:0] held;
	logic       fault_any;
	// channels whose mode change must wait on a shorted-load or latched code
	always_comb begin
		fault_any = 1'b0;
		for (int i = 0; i < 6; i++) begin
			held[i] = status_code[3*i+:3] inside {`LSFP_CODE_SCB, `LSFP_CODE_GLO};
			fault_any = fault_any || (status_code[3*i+:3] inside {`LSFP_CODE_SCB,
				`LSFP_CODE_GLO, `LSFP_CODE_SCG, `LSFP_CODE_OLF});
		end
	end
	property p_flag_set; (reset_input_n && !global_disable && chip_select_n && fault_any)[*2]
		|-> fault_flag_n_oe; endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not pulled on fault");
	// three cycles of margin cover the registered output stage
	property p_gate_rst; !reset_input_n[*3] |-> gate_output == 6'h00; endproperty
	a_gate_rst: assert property (p_gate_rst) else $error("gate on under reset pin");
	property p_gate_dis; global_disable[*3] |-> gate_output == 6'h00; endproperty
	a_gate_dis: assert property (p_gate_dis) else $error("gate on while disabled");
	property p_flag_cs; (chip_select_n == 1'b0)[*3] |-> !fault_flag_n_oe; endproperty
	a_flag_cs: assert property (p_flag_cs) else $error("flag driven, select low");
	property p_flag_dis; (global_disable || !reset_input_n)[*3] |-> !fault_flag_n_oe; endproperty
	a_flag_dis: assert property (p_flag_dis) else $error("flag driven, disabled");
	property p_flag_od; fault_flag_n_oe |-> fault_flag_n_out == 1'b0; endproperty
	a_flag_od: assert property (p_flag_od) else $error("flag driven high");
	property p_thr; $past(resetn) |-> threshold_to_comparator == $past(short_threshold_select);
	endproperty
	a_thr: assert property (p_thr) else $error("threshold not passed on");
	property p_shut; (short_shutdown_state & $past(short_shutdown_state) & gate_output) == 6'h00;
	endproperty
	a_shut: assert property (p_shut) else $error("gate on during shutdown");
	property p_mode; ($stable(recovery_mode_bits) && held == 6'h00)[*3] |->
		active_mode == recovery_mode_bits; endproperty
	a_mode: assert property (p_mode) else $error("mode change not applied");
endmodule : lsfp_top_chk
bind lsfp_top lsfp_top_chk u_chk (.*);

//--- verification/lsfp_host_model.sv
`timescale 1ns/1ps
// ---
// host side: select, status reads, flag wire
// ---
module lsfp_host_model (
	// clock and bench request
	input  wire logic       mclk,
	input  wire logic       rd_req,
	input  wire logic [5:0] rd_mask,
	// flag pin of the device
	input  wire logic       flag_out,
	input  wire logic       flag_oe,
	// towards the device
	output logic            chip_select_n,
	output logic [5:0]      status_read,
	output logic            fault_line
);
	// pull-up on the shared wire; the device can only pull it low
	assign fault_line = flag_oe ? flag_out : 1'b1;
	initial begin
		chip_select_n = 1'b1;
		status_read   = 6'h00;
	end
	// one read frame; the read counts at the select release
	always begin
		@(posedge mclk);
		if (rd_req) begin
			@(negedge mclk);
			chip_select_n <= 1'b0;
			repeat (4) @(negedge mclk);
			chip_select_n <= 1'b1;
			status_read   <= rd_mask;
			@(negedge mclk);
			status_read   <= 6'h00;
		end
	end
endmodule : lsfp_host_model

//--- verification/lsfp_top_bench.sv
`timescale 1ns/1ps
`include "lsfp_regs.svh"
// ---
// bench top
// ---
module lsfp_top_bench;
	typedef struct {string what; logic [17:0] exp; logic [17:0] msk;} lsfp_note_t;
	logic        mclk = 1'b0, resetn = 1'b0, reset_input_n = 1'b1, global_disable = 1'b0;
	logic        chip_select_n, fault_flag_n_out, fault_flag_n_oe, fault_line, rd_req = 1'b0;
	logic [5:0]  parallel_input = 6'h00, gate_command_bit = 6'h00, recovery_mode_bits = 6'h00;
	logic [5:0]  open_load_enable_bits = 6'h3f, status_read, pulse_on_req = 6'h00;
	logic [5:0]  pulse_off_req = 6'h00, drain_above_short_threshold = 6'h00, rd_mask = 6'h00;
	logic [5:0]  drain_above_open_load_reference = 6'h3f;
	logic [5:0]  drain_below_short_ground_reference = 6'h00;
	logic [5:0]  gate_output, active_mode, short_shutdown_state;
	logic [11:0] blanking_select = 12'h000;
	logic [17:0] short_threshold_select = 18'h0_0000, threshold_to_comparator, status_code, got;
	int          n_errors = 0, total_checks = 0, seed = 32'h513c;
	lsfp_note_t  notes[$], n;
	event        smp;
	always #12.5 mclk = ~mclk;
	// short retry and blanking units keep the run brief
	lsfp_top #(.RETRY_CYC(50), .BLANK_UNIT(4)) u_dut (.*);
	lsfp_host_model u_host (.mclk(mclk), .rd_req(rd_req), .rd_mask(rd_mask),
		.flag_out(fault_flag_n_out), .flag_oe(fault_flag_n_oe),
		.chip_select_n(chip_select_n), .status_read(status_read), .fault_line(fault_line));
	task automatic cyc(input int k);
		repeat (k) @(negedge mclk);
	endtask : cyc
	task automatic want(input string what, input logic [17:0] exp, input logic [17:0] msk);
		notes.push_back('{what, exp, msk});
		-> smp;
	endtask : want
	task automatic compare(input string what, input logic [17:0] exp, input logic [17:0] got_v);
		total_checks++;
		if (got_v !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got_v);
		end
	endtask : compare
	task automatic host_read(input logic [5:0] m);
		rd_mask = m;
		rd_req  = 1'b1;
		cyc(1);
		rd_req  = 1'b0;
		cyc(8);
	endtask : host_read
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	// watcher: drains every note against the settled outputs
	always begin
		@(smp);
		while (notes.size() > 0) begin
			n = notes.pop_front();
			case (n.what)
				"status": got = status_code;
				"gate":   got = 18'(gate_output);
				"shut":   got = 18'(short_shutdown_state);
				"mode":   got = 18'(active_mode);
				"flag":   got = 18'(fault_line);
				default:  got = threshold_to_comparator;
			endcase
			compare(n.what, n.exp & n.msk, got & n.msk);
		end
	end
	// hang guard, well beyond the roughly two thousand cycles the sequence needs
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		end_of_test;
	end
	// stimulus, changed at the falling edge
	initial begin
		cyc(16);
		resetn = 1'b1;
		cyc(20);
		want("status", {6{`LSFP_CODE_NO_OFF}}, 18'h3_ffff);
		want("flag", 18'h0_0001, 18'h0_0001);
		short_threshold_select = 18'($random(seed));
		cyc(3);
		want("thr", short_threshold_select, 18'h3_ffff);
		// ground short, open load, and open load with its check switched off
		drain_below_short_ground_reference = 6'h01;
		drain_above_open_load_reference = 6'h38;
		open_load_enable_bits = 6'h3b;
		cyc(`LSFP_FILTER_CYC + 20);
		want("status", 18'h0_011a, 18'h0_01ff);
		want("flag", 18'h0_0000, 18'h0_0001);
		host_read(6'h07);
		cyc(`LSFP_FILTER_CYC);
		want("status", 18'h0_01ff, 18'h0_01ff);
		drain_below_short_ground_reference = 6'h00;
		drain_above_open_load_reference = 6'h3f;
		open_load_enable_bits = 6'h3f;
		cyc(`LSFP_FILTER_CYC + 20);
		// latch-off: turn on into a shorted load
		drain_above_short_threshold = 6'h30;
		parallel_input = 6'h10;
		cyc(3);
		want("gate", 18'h0_0010, 18'h0_0010);
		cyc(10);
		want("status", 18'h0_6000, 18'h0_7000);
		want("shut", 18'h0_0010, 18'h0_0010);
		want("gate", 18'h0_0000, 18'h0_0010);
		host_read(6'h10);
		want("status", 18'h0_5000, 18'h0_7000);
		recovery_mode_bits = 6'h10;
		cyc(3);
		want("mode", 18'h0_0000, 18'h0_0010);
		drain_above_short_threshold = 6'h20;
		pulse_off_req = 6'h10;
		cyc(1);
		pulse_off_req = 6'h00;
		cyc(20);
		want("shut", 18'h0_0000, 18'h0_0010);
		want("gate", 18'h0_0010, 18'h0_0010);
		want("mode", 18'h0_0010, 18'h0_0010);
		// auto-retry: short appears while on, filter catches it
		drain_above_short_threshold = 6'h30;
		cyc(`LSFP_FILTER_CYC + 10);
		want("shut", 18'h0_0010, 18'h0_0010);
		for (int k = 0; k < 200 && gate_output[4] !== 1'b1; k++)
			cyc(1);
		want("gate", 18'h0_0010, 18'h0_0010);
		cyc(12);
		want("gate", 18'h0_0000, 18'h0_0010);
		recovery_mode_bits = 6'h00;
		cyc(3);
		want("mode", 18'h0_0010, 18'h0_0010);
		host_read(6'h10);
		want("mode", 18'h0_0000, 18'h0_0010);
		// latched channel released by a disable pulse
		gate_command_bit = 6'h20;
		cyc(15);
		want("shut", 18'h0_0020, 18'h0_0020);
		global_disable = 1'b1;
		cyc(4);
		want("gate", 18'h0_0000, 18'h0_003f);
		global_disable = 1'b0;
		cyc(2);
		want("shut", 18'h0_0000, 18'h0_0020);
		// reset pin low: a commanded healthy gate drops and the flag is released
		parallel_input = 6'h11;
		cyc(3);
		want("gate", 18'h0_0001, 18'h0_0001);
		reset_input_n = 1'b0;
		cyc(4);
		want("gate", 18'h0_0000, 18'h0_003f);
		want("flag", 18'h0_0001, 18'h0_0001);
		reset_input_n = 1'b1;
		cyc(2);
		end_of_test;
	end
endmodule : lsfp_top_bench
